// ==== rtl/external_bus_transfer_port.sv ====
`timescale 1ns/100ps
`default_nettype none
// external bus master port: one transfer per request, sized by the request, port width reported back
module external_bus_transfer_port (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // mode straps
    input wire logic syncMode,
    input wire logic fastTerm,
    // core request side
    input wire logic reqValid,
    output logic reqReady,
    input wire logic reqWrite,
    input wire logic [2:0] reqSpace,
    input wire logic [1:0] reqSize,
    input wire logic [31:0] reqAddr,
    input wire logic [31:0] reqWdata,
    // core answer side
    output logic rspValid,
    output logic [31:0] rspRdata,
    output logic [1:0] rspPort,
    output logic rspErr,
    // bus outputs
    output logic [31:0] busAddr,
    output logic [31:0] busDataOut,
    output logic busDataOe,
    output logic cycleStart_n,
    output logic readWrite,
    output logic [2:0] busSpace,
    output logic [1:0] busSize,
    output logic addrStrobe_n,
    output logic dataStrobe_n,
    // bus inputs
    input wire logic [31:0] busDataIn,
    input wire logic ack0_n,
    input wire logic ack1_n,
    input wire logic busErr_n
);
    bus_port_pkg::cyc_state_e state_r; // cycle sequencer
    logic [34:0] sampled; // resolved data, acks and error
    logic [1:0] ackIn; // resolved termination, active high
    logic errIn; // resolved bus error, active high
    logic termSeen; // termination recognised this clock

    // inputs through falling-edge sampler
    input_sampler #(.W(35)) u_sampler (
        .clk(clk),
        .reset(reset),
        .syncMode(syncMode),
        .pinIn({~busErr_n, ~ack1_n, ~ack0_n, busDataIn}),
        .sampled(sampled)
    );

    assign ackIn = sampled[33:32];
    assign errIn = sampled[34];
    // any width ack or error ends the cycle
    assign termSeen = (ackIn != 2'h0) || errIn;

    // decode port width from acks; none means no termination
    // ack0 alone means a byte port, ack1 alone a word port, both a long port
    function automatic logic [1:0] port_code(input logic [1:0] ack);
        port_code = ~{ack[0], ack[1]};
    endfunction

    // sequencer: start, address, wait states, end
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_r <= bus_port_pkg::ST_IDLE;
        end else begin
            unique case (state_r)
                bus_port_pkg::ST_IDLE: begin
                    if (reqValid) begin
                        state_r <= bus_port_pkg::ST_ADDR;
                    end
                end
                bus_port_pkg::ST_ADDR: begin
                    // fast termination skips input wait
                    if (fastTerm) begin
                        state_r <= bus_port_pkg::ST_END;
                    end else begin
                        state_r <= bus_port_pkg::ST_WAIT;
                    end
                end
                bus_port_pkg::ST_WAIT: begin
                    // hold open until device terminates
                    if (termSeen) begin
                        state_r <= bus_port_pkg::ST_END;
                    end
                end
                bus_port_pkg::ST_END: begin
                    state_r <= bus_port_pkg::ST_IDLE;
                end
                default: begin
                    state_r <= bus_port_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // latch address and control for the cycle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            busAddr <= bus_port_pkg::ADDR_RST;
            busDataOut <= bus_port_pkg::DATA_RST;
            readWrite <= 1'b1;
            busSpace <= 3'h0;
            busSize <= bus_port_pkg::SIZE_LONG;
        end else if (state_r == bus_port_pkg::ST_IDLE && reqValid) begin
            busAddr <= reqAddr;
            busDataOut <= reqWdata;
            readWrite <= ~reqWrite;
            busSpace <= reqSpace;
            busSize <= reqSize;
        end
    end

    // start pulse in first clock, strobes through the cycle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cycleStart_n <= 1'b1;
            addrStrobe_n <= 1'b1;
            dataStrobe_n <= 1'b1;
            busDataOe <= 1'b0;
        end else begin
            cycleStart_n <= ~(state_r == bus_port_pkg::ST_IDLE && reqValid);
            // strobes go high on termination
            if (state_r == bus_port_pkg::ST_IDLE && reqValid) begin
                addrStrobe_n <= 1'b0;
                dataStrobe_n <= ~reqWrite ? 1'b0 : 1'b1;
                busDataOe <= reqWrite;
            end else if (state_r == bus_port_pkg::ST_ADDR) begin
                dataStrobe_n <= 1'b0;
                if (fastTerm) begin
                    addrStrobe_n <= 1'b1;
                    dataStrobe_n <= 1'b1;
                end
            end else if (state_r == bus_port_pkg::ST_WAIT && termSeen) begin
                addrStrobe_n <= 1'b1;
                dataStrobe_n <= 1'b1;
            end else if (state_r == bus_port_pkg::ST_END) begin
                busDataOe <= 1'b0;
            end
        end
    end

    // answer: read data, port width, error at end of cycle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rspValid <= 1'b0;
            rspRdata <= bus_port_pkg::DATA_RST;
            rspPort <= bus_port_pkg::PORT_NONE;
            rspErr <= 1'b0;
        end else begin
            rspValid <= 1'b0;
            if (state_r == bus_port_pkg::ST_WAIT && termSeen) begin
                rspValid <= 1'b1;
                rspRdata <= sampled[31:0];
                rspPort <= port_code(ackIn);
                rspErr <= errIn;
            end else if (state_r == bus_port_pkg::ST_ADDR && fastTerm) begin
                // chip-select region is assumed full width
                rspValid <= 1'b1;
                rspRdata <= busDataIn;
                rspPort <= bus_port_pkg::PORT_32;
                rspErr <= 1'b0;
            end
        end
    end

    assign reqReady = (state_r == bus_port_pkg::ST_IDLE);
endmodule
`default_nettype wire

// ==== rtl/bus_port_pkg.sv ====
package bus_port_pkg;
    // port width codes returned by the addressed device
    localparam logic [1:0] PORT_32 = 2'h0;
    localparam logic [1:0] PORT_8 = 2'h1;
    localparam logic [1:0] PORT_16 = 2'h2;
    localparam logic [1:0] PORT_NONE = 2'h3;
    // transfer size codes on the size outputs
    localparam logic [1:0] SIZE_LONG = 2'h0;
    localparam logic [1:0] SIZE_BYTE = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;
    localparam logic [1:0] SIZE_3B = 2'h3;
    // widths
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int SPACE_W = 3;
    // reset values
    localparam logic [31:0] ADDR_RST = 32'h0000_0000;
    localparam logic [31:0] DATA_RST = 32'h0000_0000;
    // bus cycle states
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ADDR = 3'h1,
        ST_WAIT = 3'h2,
        ST_END = 3'h3
    } cyc_state_e;
endpackage

// ==== rtl/input_sampler.sv ====
`timescale 1ns/100ps
`default_nettype none
// captures bus inputs on the falling edge, then a rising-edge stage, optionally through a third stage
module input_sampler #(
    parameter int W = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // mode
    input wire logic syncMode,
    // inputs from pins and resolved result
    input wire logic [W-1:0] pinIn,
    output logic [W-1:0] sampled
);
    logic [W-1:0] fallCap_r; // falling-edge capture, read only by the next stage
    logic [W-1:0] stage2_r; // resolved copy in rising-edge domain
    logic [W-1:0] stage3_r; // extra stage for asynchronous mode

    // latch level at falling edge of the clock
    always_ff @(negedge clk or posedge reset) begin
        if (reset) begin
            fallCap_r <= '0;
        end else begin
            fallCap_r <= pinIn;
        end
    end

    // second flop gives metastable capture time to settle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            stage2_r <= '0;
            stage3_r <= '0;
        end else begin
            stage2_r <= fallCap_r;
            stage3_r <= stage2_r;
        end
    end

    // async mode pays one more clock of latency
    assign sampled = syncMode ? stage2_r : stage3_r;
endmodule
`default_nettype wire

// ==== sim/bus_port_checker.sv ====
`timescale 1ns/100ps
`default_nettype none
// watches cycle framing at the pins
module bus_port_checker (
    input wire logic clk, reset, syncMode, fastTerm, reqValid, reqReady, reqWrite,
    input wire logic rspValid, cycleStart_n, readWrite, addrStrobe_n, dataStrobe_n,
    input wire logic ack0_n, ack1_n, busErr_n, busDataOe,
    input wire logic [2:0] reqSpace, busSpace,
    input wire logic [1:0] reqSize, busSize,
    input wire logic [31:0] reqAddr, busAddr
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // request taken at this edge
    sequence s_take; reqValid && reqReady; endsequence
    // address strobe just dropped, full-width ack one clock on
    sequence s_ack; $fell(addrStrobe_n) ##1 (!ack0_n && !ack1_n); endsequence
    property p_fast; s_take ##0 fastTerm |-> ##1 !addrStrobe_n ##1 rspValid; endproperty
    a_fast: assert property (p_fast) else $error("fast cycle");
    property p_start; $fell(cycleStart_n) |=> cycleStart_n; endproperty
    a_start: assert property (p_start) else $error("start width");
    property p_field; $fell(addrStrobe_n) |-> busAddr == $past(reqAddr, 1)
        && readWrite == !$past(reqWrite, 1) && busSize == $past(reqSize, 1)
        && busSpace == $past(reqSpace, 1); endproperty
    a_field: assert property (p_field) else $error("cycle fields");
    // data lines driven for writes only, from the first strobe clock
    property p_oe; $fell(addrStrobe_n) |-> busDataOe == !readWrite; endproperty
    a_oe: assert property (p_oe) else $error("data drive");
    // no termination for six clocks: the cycle must stay open
    property p_hold; (!fastTerm && ack0_n && ack1_n && busErr_n)[*6] ##0 !addrStrobe_n
        |=> !addrStrobe_n; endproperty
    a_hold: assert property (p_hold) else $error("early end");
    property p_rel; rspValid |-> addrStrobe_n && dataStrobe_n; endproperty
    a_rel: assert property (p_rel) else $error("strobes held");
    property p_pulse; rspValid |=> !rspValid; endproperty
    a_pulse: assert property (p_pulse) else $error("long answer");
    property p_busy; !addrStrobe_n |-> !reqReady; endproperty
    a_busy: assert property (p_busy) else $error("ready in cycle");
    property p_sync; syncMode && !fastTerm ##0 s_ack |-> ##[1:3] rspValid; endproperty
    a_sync: assert property (p_sync) else $error("sync cycle");
endmodule
`default_nettype wire

// ==== sim/bus_device_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// far-side memory: waits dly clocks, then ends the cycle at width portCode
module bus_device_model (
    input wire logic clk, addrStrobe_n, readWrite, errOn,
    input wire logic [31:0] busAddr, busDataOut,
    input wire logic [3:0] dly,
    input wire logic [1:0] portCode,
    output logic ack0_n = 1'h1, ack1_n = 1'h1, busErr_n = 1'h1,
    output logic [31:0] busDataIn, lastWr
);
    logic [3:0] cnt = 4'h0; // clocks since strobe seen
    logic [31:0] held = 32'h0; // last data shown
    // stale data toggles every clock so it never passes for fresh
    assign busDataIn = !addrStrobe_n && readWrite ? busAddr ^ 32'h5A5A_0F0F : ~held;
    always @(posedge clk) #1 begin
        cnt <= addrStrobe_n ? 4'h0 : cnt + 4'h1;
        held <= busDataIn;
        if (addrStrobe_n)
            {ack1_n, ack0_n, busErr_n} <= 3'h7; // pulled-up lines idle high
        else if (cnt == dly) begin
            busErr_n <= !errOn;
            ack0_n <= errOn || portCode == bus_port_pkg::PORT_16;
            ack1_n <= errOn || portCode == bus_port_pkg::PORT_8;
            lastWr <= busDataOut;
        end
    end
endmodule
`default_nettype wire

// ==== sim/external_bus_transfer_port_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module external_bus_transfer_port_tb;
    logic clk = 1'h0, reset = 1'h1, syncMode = 1'h1, fastTerm = 1'h0;
    logic reqValid = 1'h0, reqWrite = 1'h0, errOn = 1'h0;
    logic reqReady, rspValid, rspErr, busDataOe, cycleStart_n, readWrite;
    logic addrStrobe_n, dataStrobe_n, ack0_n, ack1_n, busErr_n;
    logic [2:0] reqSpace = 3'h0, busSpace;
    logic [1:0] reqSize = 2'h0, portCode = 2'h0, rspPort, busSize;
    logic [3:0] dly = 4'h0;
    logic [31:0] reqAddr = 32'h0, reqWdata = 32'h0, rspRdata, busAddr, busDataOut;
    logic [31:0] busDataIn, lastWr;
    logic [69:0] e, expQ[$]; // mask then expected {error, port, data}
    int num_errors = 0, total_checks = 0;
    external_bus_transfer_port i_dut (.*);
    bus_device_model i_dev (.*);
    initial forever #4 clk = ~clk;
    task automatic give_verdict();
        if (num_errors == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic cmp(input logic [34:0] got, input logic [34:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one request: wait for idle, present it, hold it to the taking edge
    task automatic req(input int md, input logic wr, er, input logic [1:0] pc,
        input logic [3:0] d);
        logic [34:0] m, x;
        for (int n = 0; reqReady !== 1'h1; n++) begin
            if (n > 60) begin
                num_errors++;
                give_verdict();
            end
            @(posedge clk) #1;
        end
        syncMode = md != 0;
        fastTerm = md == 2;
        {reqWrite, portCode, dly, errOn} = {wr, pc, d, er};
        reqAddr = $urandom;
        reqWdata = $urandom;
        reqSpace = 3'($urandom);
        reqSize = 2'($urandom);
        // data only checked where the lanes are certain: full width, no error
        m = {1'h1, er ? 2'h0 : 2'h3,
            er || !(fastTerm || pc == bus_port_pkg::PORT_32) ? 32'h0 : 32'hFFFF_FFFF};
        x = m & {er, fastTerm ? bus_port_pkg::PORT_32 : pc,
            wr ? reqWdata : reqAddr ^ 32'h5A5A_0F0F};
        reqValid = 1'h1;
        @(posedge clk) #1;
        expQ.push_back({m, x});
        reqValid = 1'h0;
    endtask
    // answer watcher: each answer against the oldest note
    always @(negedge clk) begin
        if (rspValid === 1'h1) begin
            e = expQ.pop_front();
            cmp({rspErr, rspPort, readWrite ? rspRdata : lastWr} & e[69:35], e[34:0]);
        end
    end
    initial begin
        void'($urandom(32'hD15D));
        repeat (2) @(posedge clk);
        #1 reset = 1'h0;
        // modes rotate async, sync, fast; widths and waits random
        for (int i = 0; i < 90; i++) begin
            req(i % 3, 1'($urandom), i % 3 != 2 && i % 7 == 3, 2'($urandom % 3),
                i % 3 == 2 ? 4'h0 : 4'($urandom % 9));
        end
        for (int n = 0; n < 40 && expQ.size() > 0; n++) @(posedge clk);
        if (expQ.size() > 0) num_errors++;
        give_verdict();
    end
endmodule
bind external_bus_transfer_port bus_port_checker i_chk (.*);
`default_nettype wire
